/* obs_cfg.svh */
`ifndef OBS_CFG_SVH
`define OBS_CFG_SVH

// ==========================================================
// Register map
`define OBS_ADDR_W 8
`define OBS_OFS_CTRL 8'h00
`define OBS_OFS_STATUS 8'h04
`define OBS_OFS_CLEAR 8'h08
`define OBS_OFS_IRQ_EN 8'h0c

// ==========================================================
// Control fields
`define OBS_CTRL_STOP_IN_WAIT 0
`define OBS_CTRL_SLEEP 1
`define OBS_CTRL_PEN_LSB 2
`define OBS_CTRL_RESET 32'h0000_0000

// ==========================================================
// Status fields
`define OBS_ST_W 5
`define OBS_ST_SYNC_OK 0
`define OBS_ST_RX_OK 1
`define OBS_ST_ERROR 2
`define OBS_ST_SLOT_MM 3
`define OBS_ST_WAKEUP 4
`define OBS_ST_RESET 5'h00
`define OBS_IRQ_EN_RESET 5'h00

// ==========================================================
// Bus responses
`define OBS_RESP_OKAY 2'h0
`define OBS_RESP_SLVERR 2'h2

// ==========================================================
// Pulse timing
`define OBS_CLK_MHZ 25
`define OBS_PULSE_NS 50
`define OBS_PULSE_CYC ((`OBS_PULSE_NS * `OBS_CLK_MHZ + 999) / 1000)
`define OBS_PCNT_W 2

`endif

/* obs_pkg.sv */
`include "obs_cfg.svh"

package obs_pkg;

    typedef enum logic [2:0] {
        OBS_SEL_CTRL,
        OBS_SEL_STATUS,
        OBS_SEL_CLEAR,
        OBS_SEL_IRQ_EN,
        OBS_SEL_NONE
    } obs_sel_t;

    typedef struct packed {
        logic out;
        logic [`OBS_PCNT_W-1:0] cnt;
    } obs_pulse_st_t;

    typedef struct packed {
        logic aw_full;
        logic [`OBS_ADDR_W-1:0] aw_addr;
        logic w_full;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic stop_in_wait;
        logic sleep;
        logic [3:0] pulse_en;
        logic [`OBS_ST_W-1:0] status;
        logic [`OBS_ST_W-1:0] irq_en;
        logic rx_s1;
        logic rx_s2;
        logic rx_s3;
        logic tx;
        logic run;
    } obs_st_t;

endpackage : obs_pkg

/* obs_pulse_gen.sv */
`timescale 1ns/10ps
`include "obs_cfg.svh"

module obs_pulse_gen (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Control
    input wire logic en,
    input wire logic trig,
    // Pin
    output logic pulse_o
);

    obs_pkg::obs_pulse_st_t st_r;
    obs_pkg::obs_pulse_st_t st_nxt;

    // ==========================================================
    // Stretcher
    always_comb
    begin
        st_nxt = st_r;
        if (!en)
        begin
            // Disabled output held low, pending stretch dropped
            st_nxt.out = 1'b0;
            st_nxt.cnt = '0;
        end
        else if (trig)
        begin
            // Retrigger restarts the full width
            st_nxt.out = 1'b1;
            st_nxt.cnt = `OBS_PCNT_W'(`OBS_PULSE_CYC - 1);
        end
        else if (st_r.cnt != '0)
        begin
            st_nxt.out = 1'b1;
            st_nxt.cnt = st_r.cnt - `OBS_PCNT_W'(1);
        end
        else
        begin
            st_nxt.out = 1'b0;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign pulse_o = st_r.out;

endmodule : obs_pulse_gen

/* obs_top.sv */
// Local design decisions: the AXI4-Lite register port and the register addresses.
`timescale 1ns/10ps
`include "obs_cfg.svh"

module obs_top (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // AXI4-Lite write address
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [`OBS_ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    // AXI4-Lite write data
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    // AXI4-Lite write response
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // AXI4-Lite read address
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [`OBS_ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    // AXI4-Lite read data
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    // CPU low-power state
    input wire logic cpu_wait,
    // Protocol core events, one-cycle pulses
    input wire logic ev_sync_ok,
    input wire logic ev_rx_ok,
    input wire logic ev_format_err,
    input wire logic ev_pulse_err,
    input wire logic ev_slot_mismatch,
    // Protocol core data path
    output logic core_run,
    output logic core_rx_data,
    input wire logic core_tx_data,
    // Bus pins
    input wire logic serial_rx_pin,
    output logic serial_tx_pin,
    output logic sync_ok_pulse,
    output logic rx_ok_pulse,
    output logic error_pulse,
    output logic slot_mismatch_pulse,
    // Interrupt
    output logic irq
);

    obs_pkg::obs_st_t st_r;
    obs_pkg::obs_st_t st_nxt;

    logic [3:0] pulse_trig;
    logic [3:0] pulse_out;

    // ==========================================================
    // Address decode, shared by read and write
    function automatic obs_pkg::obs_sel_t obs_sel(input logic [`OBS_ADDR_W-1:0] addr);
        obs_pkg::obs_sel_t sel;
        sel = obs_pkg::OBS_SEL_NONE;
        unique case ({addr[`OBS_ADDR_W-1:2], 2'h0})
            `OBS_OFS_CTRL: sel = obs_pkg::OBS_SEL_CTRL;
            `OBS_OFS_STATUS: sel = obs_pkg::OBS_SEL_STATUS;
            `OBS_OFS_CLEAR: sel = obs_pkg::OBS_SEL_CLEAR;
            `OBS_OFS_IRQ_EN: sel = obs_pkg::OBS_SEL_IRQ_EN;
            default: sel = obs_pkg::OBS_SEL_NONE;
        endcase
        return sel;
    endfunction : obs_sel

    // ==========================================================
    // Event decode, shared by status bits and pulse pins
    function automatic logic [3:0] obs_ev_map(
        input logic run,
        input logic sync_ok,
        input logic rx_ok,
        input logic format_err,
        input logic pulse_err,
        input logic slot_mm
    );
        logic [3:0] v;
        v = 4'h0;
        // Halted core: events dropped, neither flagged nor pulsed
        if (run)
        begin
            v[0] = sync_ok;
            v[1] = rx_ok;
            v[2] = format_err || pulse_err || slot_mm;
            v[3] = slot_mm;
        end
        return v;
    endfunction : obs_ev_map

    // ==========================================================
    // Next state
    always_comb
    begin
        logic wake_edge;
        logic [`OBS_ST_W-1:0] set_v;
        logic [`OBS_ST_W-1:0] clr_v;
        obs_pkg::obs_sel_t wsel;
        obs_pkg::obs_sel_t rsel;
        wake_edge = 1'b0;
        set_v = '0;
        clr_v = '0;
        wsel = obs_pkg::OBS_SEL_NONE;
        rsel = obs_pkg::OBS_SEL_NONE;
        st_nxt = st_r;

        // Pin path, first stage read only by the second
        st_nxt.rx_s1 = serial_rx_pin;
        st_nxt.rx_s2 = st_r.rx_s1;
        st_nxt.rx_s3 = st_r.rx_s2;
        // Idle high while halted, so a stopped core cannot jam the line
        st_nxt.tx = st_r.run ? core_tx_data : 1'b1;

        // Core halts when sleeping or when wait stops it
        st_nxt.run = !st_r.sleep && !(cpu_wait && st_r.stop_in_wait);

        // Bus activity while asleep raises the wake-up event
        // Clocked detection: mclk must keep running while asleep
        wake_edge = st_r.sleep && st_r.rx_s3 && !st_r.rx_s2;

        // Same gated events as the pulse pins
        set_v[`OBS_ST_SYNC_OK] = pulse_trig[0];
        set_v[`OBS_ST_RX_OK] = pulse_trig[1];
        set_v[`OBS_ST_ERROR] = pulse_trig[2];
        set_v[`OBS_ST_SLOT_MM] = pulse_trig[3];
        set_v[`OBS_ST_WAKEUP] = wake_edge;

        // Write channel: address and data taken in either order
        if (s_axi_awvalid && !st_r.aw_full)
        begin
            st_nxt.aw_full = 1'b1;
            st_nxt.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st_r.w_full)
        begin
            st_nxt.w_full = 1'b1;
            st_nxt.w_data = s_axi_wdata;
            st_nxt.w_strb = s_axi_wstrb;
        end
        if (st_r.bvalid && s_axi_bready)
        begin
            st_nxt.bvalid = 1'b0;
        end
        // Execute only once the previous response has been taken
        if (st_r.aw_full && st_r.w_full && !st_r.bvalid)
        begin
            wsel = obs_sel(st_r.aw_addr);
            st_nxt.aw_full = 1'b0;
            st_nxt.w_full = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp = `OBS_RESP_OKAY;
            unique case (wsel)
                obs_pkg::OBS_SEL_CTRL:
                begin
                    if (st_r.w_strb[0])
                    begin
                        st_nxt.stop_in_wait = st_r.w_data[`OBS_CTRL_STOP_IN_WAIT];
                        st_nxt.sleep = st_r.w_data[`OBS_CTRL_SLEEP];
                        // A cleared enable cuts a running stretch at once
                        st_nxt.pulse_en = st_r.w_data[`OBS_CTRL_PEN_LSB+3:`OBS_CTRL_PEN_LSB];
                    end
                end
                obs_pkg::OBS_SEL_CLEAR:
                begin
                    if (st_r.w_strb[0])
                    begin
                        clr_v = st_r.w_data[`OBS_ST_W-1:0];
                    end
                end
                obs_pkg::OBS_SEL_IRQ_EN:
                begin
                    if (st_r.w_strb[0])
                    begin
                        st_nxt.irq_en = st_r.w_data[`OBS_ST_W-1:0];
                    end
                end
                obs_pkg::OBS_SEL_STATUS:
                begin
                    // Status is read-only, write ignored
                end
                obs_pkg::OBS_SEL_NONE:
                begin
                    // Unmapped offset: error answer, data dropped
                    st_nxt.bresp = `OBS_RESP_SLVERR;
                end
            endcase
        end

        // Set wins over a clear in the same cycle
        st_nxt.status = (st_r.status & ~clr_v) | set_v;

        // Read channel
        if (st_r.rvalid && s_axi_rready)
        begin
            st_nxt.rvalid = 1'b0;
        end
        // One read in flight; a new address waits until the data is taken
        if (s_axi_arvalid && !st_r.rvalid)
        begin
            rsel = obs_sel(s_axi_araddr);
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp = `OBS_RESP_OKAY;
            st_nxt.rdata = 32'h0000_0000;
            unique case (rsel)
                obs_pkg::OBS_SEL_CTRL:
                begin
                    st_nxt.rdata[`OBS_CTRL_STOP_IN_WAIT] = st_r.stop_in_wait;
                    st_nxt.rdata[`OBS_CTRL_SLEEP] = st_r.sleep;
                    st_nxt.rdata[`OBS_CTRL_PEN_LSB+3:`OBS_CTRL_PEN_LSB] = st_r.pulse_en;
                end
                obs_pkg::OBS_SEL_STATUS:
                begin
                    st_nxt.rdata[`OBS_ST_W-1:0] = st_r.status;
                end
                obs_pkg::OBS_SEL_IRQ_EN:
                begin
                    st_nxt.rdata[`OBS_ST_W-1:0] = st_r.irq_en;
                end
                obs_pkg::OBS_SEL_CLEAR:
                begin
                    // Write-only, reads zero
                end
                obs_pkg::OBS_SEL_NONE:
                begin
                    st_nxt.rresp = `OBS_RESP_SLVERR;
                end
            endcase
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            st_r <= '0;
            st_r.stop_in_wait <= 1'((`OBS_CTRL_RESET >> `OBS_CTRL_STOP_IN_WAIT) & 32'h1);
            st_r.sleep <= 1'((`OBS_CTRL_RESET >> `OBS_CTRL_SLEEP) & 32'h1);
            st_r.pulse_en <= 4'(`OBS_CTRL_RESET >> `OBS_CTRL_PEN_LSB);
            st_r.status <= `OBS_ST_RESET;
            st_r.irq_en <= `OBS_IRQ_EN_RESET;
            // Synchroniser preset to the idle level: no false wake edge after reset
            st_r.rx_s1 <= 1'b1;
            st_r.rx_s2 <= 1'b1;
            st_r.rx_s3 <= 1'b1;
            st_r.tx <= 1'b1;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // ==========================================================
    // Status pulses, retriggered by gated core events
    assign pulse_trig = obs_ev_map(st_r.run, ev_sync_ok, ev_rx_ok, ev_format_err,
        ev_pulse_err, ev_slot_mismatch);

    for (genvar i = 0; i < 4; i++)
    begin : g_pulse
        obs_pulse_gen u_pulse (
            .mclk(mclk),
            .rst_b(rst_b),
            .en(st_r.pulse_en[i]),
            .trig(pulse_trig[i]),
            .pulse_o(pulse_out[i])
        );
    end

    // ==========================================================
    // Outputs
    assign s_axi_awready = !st_r.aw_full;
    assign s_axi_wready = !st_r.w_full;
    assign s_axi_bvalid = st_r.bvalid;
    assign s_axi_bresp = st_r.bresp;
    assign s_axi_arready = !st_r.rvalid;
    assign s_axi_rvalid = st_r.rvalid;
    assign s_axi_rdata = st_r.rdata;
    assign s_axi_rresp = st_r.rresp;

    // ==========================================================
    // Core and pin outputs
    assign core_run = st_r.run;
    assign core_rx_data = st_r.rx_s2;
    assign serial_tx_pin = st_r.tx;
    assign sync_ok_pulse = pulse_out[0];
    assign rx_ok_pulse = pulse_out[1];
    assign error_pulse = pulse_out[2];
    assign slot_mismatch_pulse = pulse_out[3];

    // ==========================================================
    // Level interrupt, also serves as the wake-up request
    assign irq = |(st_r.status & st_r.irq_en);

endmodule : obs_top

/* obs_xcvr.sv */
`timescale 1ns/10ps

module obs_xcvr (
    // Clock
    input logic mclk,
    // Bench control
    input logic echo,
    input logic wake,
    // Line
    input logic tx,
    output logic rx
);
    initial rx = 1'b1;
    // Idle light reads high; echo stands in for a star that returns our frames
    always @(posedge mclk)
        rx <= wake ? 1'b0 : (echo ? tx : 1'b1);
endmodule : obs_xcvr

/* obs_top_assertions.sv */
`timescale 1ns/10ps

module obs_chk (
    // Clock and reset
    input logic mclk,
    input logic rst_b,
    // Watched ports
    input logic s_axi_bvalid,
    input logic ev_sync_ok,
    input logic ev_rx_ok,
    input logic ev_format_err,
    input logic ev_pulse_err,
    input logic ev_slot_mismatch,
    input logic core_run,
    input logic core_rx_data,
    input logic core_tx_data,
    input logic serial_rx_pin,
    input logic serial_tx_pin,
    input logic sync_ok_pulse,
    input logic rx_ok_pulse,
    input logic error_pulse,
    input logic slot_mismatch_pulse,
    input logic irq
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);

    // ==========
    // Properties
    a_sync_cause: assert property ($rose(sync_ok_pulse) |-> $past(ev_sync_ok && core_run))
        else $error("sync pulse without cause");
    a_rx_cause: assert property ($rose(rx_ok_pulse) |-> $past(ev_rx_ok && core_run))
        else $error("rx pulse without cause");
    a_err_cause: assert property ($rose(error_pulse) |->
        $past(core_run && (ev_format_err || ev_pulse_err || ev_slot_mismatch)))
        else $error("error pulse without cause");
    a_slot_cause: assert property ($rose(slot_mismatch_pulse) |-> $past(ev_slot_mismatch && core_run))
        else $error("slot pulse without cause");
    // A write may cancel a pulse by clearing its enable
    a_sync_len: assert property ($rose(sync_ok_pulse) |=> sync_ok_pulse || $past(s_axi_bvalid))
        else $error("sync pulse too short");
    a_err_len: assert property ($rose(error_pulse) |=> error_pulse || $past(s_axi_bvalid))
        else $error("error pulse too short");
    a_sync_max: assert property (sync_ok_pulse && $past(sync_ok_pulse) && $past(sync_ok_pulse, 2) |->
        $past(ev_sync_ok && core_run) || $past(ev_sync_ok && core_run, 2))
        else $error("sync pulse too long");
    a_halt_quiet: assert property (!$past(core_run) && !$past(core_run, 2) |->
        !(sync_ok_pulse || rx_ok_pulse || error_pulse || slot_mismatch_pulse))
        else $error("pulse while halted");
    a_tx_path: assert property (core_run && $past(core_run) |-> serial_tx_pin == $past(core_tx_data))
        else $error("tx pin not following core");
    a_rx_path: assert property ($past(rst_b) && $past(rst_b, 2) |-> core_rx_data == $past(serial_rx_pin, 2))
        else $error("rx pin not reaching core");
    a_irq_rise: assert property ($rose(irq) |-> $rose(s_axi_bvalid) || !$past(core_run) ||
        $past(core_run && (ev_sync_ok || ev_rx_ok || ev_format_err || ev_pulse_err || ev_slot_mismatch)))
        else $error("irq without source");
    a_irq_fall: assert property ($fell(irq) |-> $rose(s_axi_bvalid))
        else $error("irq dropped without write");
    c_sync: cover property ($rose(sync_ok_pulse));
    c_slot: cover property (slot_mismatch_pulse && error_pulse);
    c_wake: cover property ($rose(irq) && !core_run);
endmodule : obs_chk

bind obs_top obs_chk i_chk (.mclk, .rst_b, .s_axi_bvalid, .ev_sync_ok, .ev_rx_ok, .ev_format_err,
    .ev_pulse_err, .ev_slot_mismatch, .core_run, .core_rx_data, .core_tx_data, .serial_rx_pin,
    .serial_tx_pin, .sync_ok_pulse, .rx_ok_pulse, .error_pulse, .slot_mismatch_pulse, .irq);

/* obs_top_tb_top.sv */
`timescale 1ns/10ps

module obs_top_tb_top;
    logic mclk = 1'b0, rst_b = 1'b0, cpu_wait = 1'b0, core_tx_data = 1'b0, echo = 1'b0, wake = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, rs = 32'h9a4b95bd;
    logic [4:0] ev = 5'h00;
    logic [3:0] prev_pl = 4'h0, hist = 4'h0, m;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, serial_rx_pin;
    wire serial_tx_pin, irq, core_run, core_rx_data;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [3:0] pl;
    logic [1:0] bq[$];
    logic [33:0] rq[$];
    logic [3:0] pq[$];
    int fail_count = 0, total_checks = 0, n;
    localparam logic [3:0] pat_tab [5] = '{4'h1, 4'h2, 4'h4, 4'h4, 4'hc};

    obs_top i_dut (.mclk, .rst_b, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_awprot(3'h0),
        .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_bvalid, .s_axi_bready,
        .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_rvalid,
        .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .cpu_wait, .ev_sync_ok(ev[0]), .ev_rx_ok(ev[1]),
        .ev_format_err(ev[2]), .ev_pulse_err(ev[3]), .ev_slot_mismatch(ev[4]), .core_run, .core_rx_data,
        .core_tx_data, .serial_rx_pin, .serial_tx_pin, .sync_ok_pulse(pl[0]), .rx_ok_pulse(pl[1]),
        .error_pulse(pl[2]), .slot_mismatch_pulse(pl[3]), .irq);
    obs_xcvr i_xcvr (.mclk, .echo, .wake, .tx(serial_tx_pin), .rx(serial_rx_pin));

    initial
    begin
        forever #20 mclk = ~mclk;
    end

    // ==========
    // Checking
    task automatic chk_rd(input logic [33:0] g, input logic [33:0] e);
        total_checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask : chk_rd

    task automatic chk_lv(input logic [3:0] g, input logic [3:0] e);
        total_checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask : chk_lv

    task results;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : results

    // Empty queue yields an impossible value so stray answers always mismatch
    always @(posedge mclk)
    begin
        if (s_axi_bvalid && s_axi_bready)
            chk_rd({32'h0, s_axi_bresp}, bq.size() ? {32'h0, bq.pop_front()} : '1);
        if (s_axi_rvalid && s_axi_rready)
            chk_rd({s_axi_rresp, s_axi_rdata}, rq.size() ? rq.pop_front() : '1);
        if (pl != 4'h0 && prev_pl == 4'h0)
            chk_lv(pl, pq.size() ? pq.pop_front() : 4'h0);
        prev_pl <= pl;
    end

    // ==========
    // Drivers
    function automatic logic [31:0] lf(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lf

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        bq.push_back(e);
        n = 0;
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge mclk);
            n++;
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end
        while (!s_axi_bvalid && n < 60);
        s_axi_bready <= 1'b0;
        if (n >= 60)
        begin
            fail_count++;
            results();
        end
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        rq.push_back(e);
        n = 0;
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge mclk);
            n++;
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end
        while (!s_axi_rvalid && n < 60);
        s_axi_rready <= 1'b0;
        if (n >= 60)
        begin
            fail_count++;
            results();
        end
    endtask : rd

    task automatic fire(input int i, input logic [3:0] e);
        @(posedge mclk);
        ev <= 5'h01 << i;
        if ((pat_tab[i] & e) != 4'h0)
            pq.push_back(pat_tab[i] & e);
        @(posedge mclk);
        ev <= 5'h00;
        repeat (4) @(posedge mclk);
    endtask : fire

    initial
    begin
        repeat (5) @(posedge mclk);
        rst_b <= 1'b1;
        rd(8'h04, 34'h0);
        wr(8'h00, 32'h3c, 2'h0);
        rd(8'h00, 34'h3c);
        wr(8'h0c, 32'h1f, 2'h0);
        rd(8'h0c, 34'h1f);
        wr(8'h10, 32'hff, 2'h2);
        rd(8'h10, {2'h2, 32'h0});
        wr(8'h04, 32'h1f, 2'h0);
        rd(8'h04, 34'h0);
        rd(8'h08, 34'h0);
        $display("test 1 done");
        for (int i = 0; i < 5; i++)
            fire(i, 4'hf);
        chk_lv({3'h0, irq}, 4'h1);
        rd(8'h04, 34'hf);
        wr(8'h08, 32'h1f, 2'h0);
        chk_lv({3'h0, irq}, 4'h0);
        $display("test 2 done");
        for (int i = 0; i < 12; i++)
        begin
            rs = lf(rs);
            m = rs[3:0];
            wr(8'h00, {26'h0, m, 2'h0}, 2'h0);
            fire(rs[7:4] % 5, m);
        end
        wr(8'h08, 32'h1f, 2'h0);
        $display("test 3 done");
        wr(8'h00, 32'h3d, 2'h0);
        cpu_wait <= 1'b1;
        repeat (3) @(posedge mclk);
        chk_lv({3'h0, core_run}, 4'h0);
        fire(1, 4'h0);
        wr(8'h00, 32'h3c, 2'h0);
        repeat (3) @(posedge mclk);
        chk_lv({3'h0, core_run}, 4'h1);
        fire(0, 4'hf);
        chk_lv({3'h0, irq}, 4'h1);
        cpu_wait <= 1'b0;
        rd(8'h04, 34'h1);
        wr(8'h08, 32'h1f, 2'h0);
        $display("test 4 done");
        wr(8'h00, 32'h3e, 2'h0);
        repeat (3) @(posedge mclk);
        chk_lv({3'h0, core_run}, 4'h0);
        wake <= 1'b1;
        repeat (3) @(posedge mclk);
        wake <= 1'b0;
        for (n = 0; !irq && n < 20; n++)
            @(posedge mclk);
        chk_lv({3'h0, irq}, 4'h1);
        rd(8'h04, 34'h10);
        wr(8'h00, 32'h3c, 2'h0);
        wr(8'h08, 32'h1f, 2'h0);
        $display("test 5 done");
        echo <= 1'b1;
        for (int i = 0; i < 40; i++)
        begin
            @(posedge mclk);
            if (i > 5)
                chk_lv({3'h0, core_rx_data}, {3'h0, hist[3]});
            hist = {hist[2:0], core_tx_data};
            rs = lf(rs);
            core_tx_data <= rs[0];
        end
        echo <= 1'b0;
        $display("test 6 done");
        chk_rd(34'(bq.size() + rq.size() + pq.size()), 34'h0);
        results();
    end
endmodule : obs_top_tb_top
